// [tpwm_consts.svh]
/*
 * offsets, field positions, reset values and fixed counts of the pwm timer.
 * assumes byte addresses on an 8-bit register address, one 32-bit word each.
 */
`ifndef TPWM_CONSTS_SVH
`define TPWM_CONSTS_SVH

// register byte addresses
`define TPWM_ADDR_CTL1 8'h00
`define TPWM_ADDR_CTL0 8'h04
`define TPWM_ADDR_COUNT 8'h08
`define TPWM_ADDR_MATCH 8'h0c
`define TPWM_ADDR_RELOAD 8'h10
`define TPWM_ADDR_STAT 8'h14
`define TPWM_ADDR_CLR 8'h18
`define TPWM_ADDR_IEN 8'h1c

// control 1 fields
`define TPWM_C1_EN 0
`define TPWM_C1_POL 1
`define TPWM_C1_PRE_LSB 2
`define TPWM_C1_MODE_LSB 5
`define TPWM_MODE_PWM 3'h3

// control 0 fields
`define TPWM_C0_ICFG_LSB 0
`define TPWM_C0_MODEHI 3
`define TPWM_C0_DEAD_LSB 8
`define TPWM_DEAD_MAX 8'h80
`define TPWM_ICFG_MATCH 2'h1

// status bits
`define TPWM_ST_RELOAD 0
`define TPWM_ST_MATCH 1

// reset values
`define TPWM_CNT_RESTART 16'h0001
`define TPWM_RST_RELOAD 16'hffff
`define TPWM_RST_MATCH 16'h0000

`endif

// [tpwm_pkg.sv]
/*
 * types shared by the pwm timer modules.
 * assumes nothing beyond a systemverilog compiler.
 */
package tpwm_pkg;
    typedef enum logic [1:0] {
        TPWM_OFF,
        TPWM_SINGLE,
        TPWM_DUAL
    } tpwm_mode_type;
endpackage : tpwm_pkg

// [tpwm_db_if.sv]
/*
 * carrier between the pwm core and its deadband stage.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface tpwm_db_if;
    logic raw;
    logic dual;
    logic [7:0] dead;
    logic p_out;
    logic n_out;
    modport src (output raw, output dual, output dead, input p_out, input n_out);
    modport gen (input raw, input dual, input dead, output p_out, output n_out);
endinterface : tpwm_db_if

`default_nettype wire

// [tpwm_prescale.sv]
/*
 * prescaler: one tick every 2**sel clock cycles.
 * assumes clear is held while the timer is stopped.
 */
`timescale 1ns/1ps
`default_nettype none

module tpwm_prescale #(
    parameter int PRE_W = 3
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // control
    input wire logic clear_i,
    input wire logic [PRE_W-1:0] sel_i,
    // tick
    output logic tick_o
);
    localparam int DIV_W = (1 << PRE_W) - 1;

    initial begin
        if (PRE_W < 1 || PRE_W > 4) $error("tpwm_prescale: PRE_W out of range");
    end

    logic [DIV_W-1:0] div_r, div_nxt;
    logic [DIV_W-1:0] limit;
    logic tick_r, tick_nxt;

    always_comb begin
        limit = DIV_W'((DIV_W+1)'(1) << sel_i) - DIV_W'(1);
        div_nxt = div_r;
        tick_nxt = 1'b0;
        if (clear_i) begin
            div_nxt = '0;
        end else if (div_r >= limit) begin
            div_nxt = '0;
            tick_nxt = 1'b1;
        end else begin
            div_nxt = div_r + DIV_W'(1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else if (ce_i) begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;

    a_tick_gap: assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && !clear_i && tick_r && sel_i == PRE_W'(1) && $stable(sel_i)) |=>
        (ce_i && !clear_i) |-> !tick_r)
        else $error("prescaler ticked on consecutive cycles at divide by two");
endmodule : tpwm_prescale

`default_nettype wire

// [tpwm_deadband.sv]
/*
 * deadband stage: drives the pwm pin and its complement.
 * assumes raw comes from a flip-flop on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tpwm_deadband (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // carrier
    tpwm_db_if.gen db
);
    logic p_r, p_nxt, n_r, n_nxt, tgt_r, tgt_nxt;
    logic [7:0] cnt_r, cnt_nxt;

    always_comb begin
        p_nxt = p_r;
        n_nxt = n_r;
        tgt_nxt = db.raw;
        cnt_nxt = cnt_r;
        if (!db.dual) begin
            p_nxt = db.raw;
            n_nxt = 1'b0;
            cnt_nxt = '0;
        end else if (db.raw != tgt_r) begin
            // inactive side drops at once, the other waits
            if (db.raw) n_nxt = 1'b0;
            else p_nxt = 1'b0;
            cnt_nxt = db.dead;
            if (db.dead == 8'h00) begin
                p_nxt = db.raw;
                n_nxt = ~db.raw;
            end
        end else if (cnt_r != 8'h00) begin
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
                p_nxt = tgt_r;
                n_nxt = ~tgt_r;
            end
        end else begin
            p_nxt = tgt_r;
            n_nxt = ~tgt_r;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            p_r <= 1'b0;
            n_r <= 1'b0;
            tgt_r <= 1'b0;
            cnt_r <= '0;
        end else if (ce_i) begin
            p_r <= p_nxt;
            n_r <= n_nxt;
            tgt_r <= tgt_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign db.p_out = p_r;
    assign db.n_out = n_r;

    a_never_both: assert property (@(posedge clock_i) disable iff (rst_i)
        db.dual |-> !(p_r && n_r))
        else $error("both pwm outputs active together");
    a_dead_delay: assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && db.dual && tgt_r == p_r && db.raw != tgt_r && db.dead == 8'h02)
        ##1 ce_i[*2] |=> (p_r == $past(tgt_r, 1) && n_r == !p_r))
        else $error("deadband of two cycles not honoured");
endmodule : tpwm_deadband

`default_nettype wire

// [tpwm_core.sv]
/*
 * pwm timer: 16-bit reloading counter with single or dual pwm output,
 * register port, sticky interrupt status.
 * assumes a one-cycle strobe register master on the same clock.
 */
`include "tpwm_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tpwm_core #(
    parameter int CNT_W = 16,
    parameter int PRE_W = 3
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // pins and interrupt
    output logic timer_output_pin_o,
    output logic timer_output_comp_o,
    output logic irq_o
);
    initial begin
        if (CNT_W != 16) $error("tpwm_core: CNT_W must be 16");
        if (PRE_W < 1 || PRE_W > 4) $error("tpwm_core: PRE_W out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] ctl1_r, ctl1_nxt;
    logic [15:0] ctl0_r, ctl0_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt, match_r, match_nxt, reload_r, reload_nxt;
    logic [1:0] stat_r, stat_nxt, ien_r, ien_nxt;
    logic pwm_r, pwm_nxt, irq_r, irq_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic en, pol, tick, step, at_reload, at_match, cnt_wr;
    logic [2:0] mode_lo;
    logic [1:0] icfg, ev;
    logic [7:0] dead;
    tpwm_pkg::tpwm_mode_type mode;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = wr_i && (a == b);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////
    // decode

    always_comb begin
        en = ctl1_r[`TPWM_C1_EN];
        pol = ctl1_r[`TPWM_C1_POL];
        mode_lo = ctl1_r[`TPWM_C1_MODE_LSB +: 3];
        icfg = ctl0_r[`TPWM_C0_ICFG_LSB +: 2];
        dead = ctl0_r[`TPWM_C0_DEAD_LSB +: 8];
        if (dead > `TPWM_DEAD_MAX) dead = `TPWM_DEAD_MAX;
        if (mode_lo != `TPWM_MODE_PWM) mode = tpwm_pkg::TPWM_OFF;
        else if (ctl0_r[`TPWM_C0_MODEHI]) mode = tpwm_pkg::TPWM_DUAL;
        else mode = tpwm_pkg::TPWM_SINGLE;
    end

    tpwm_prescale #(
        .PRE_W(PRE_W)
    ) u_pre (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clear_i(!en || mode == tpwm_pkg::TPWM_OFF),
        .sel_i(ctl1_r[`TPWM_C1_PRE_LSB +: PRE_W]),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////
    // counter, output level, status

    always_comb begin
        step = en && tick && (mode != tpwm_pkg::TPWM_OFF);
        at_reload = step && (cnt_r == reload_r);
        at_match = step && !at_reload && (cnt_r + CNT_W'(1) == match_r);
        cnt_wr = hit(addr_i, `TPWM_ADDR_COUNT);
        ctl1_nxt = hit(addr_i, `TPWM_ADDR_CTL1) ? wdata_i[7:0] : ctl1_r;
        ctl0_nxt = hit(addr_i, `TPWM_ADDR_CTL0) ? wdata_i[15:0] : ctl0_r;
        match_nxt = hit(addr_i, `TPWM_ADDR_MATCH) ? wdata_i[CNT_W-1:0] : match_r;
        reload_nxt = hit(addr_i, `TPWM_ADDR_RELOAD) ? wdata_i[CNT_W-1:0] : reload_r;
        ien_nxt = hit(addr_i, `TPWM_ADDR_IEN) ? wdata_i[1:0] : ien_r;
        cnt_nxt = cnt_r;
        pwm_nxt = pwm_r;
        if (cnt_wr) begin
            cnt_nxt = wdata_i[CNT_W-1:0];
        end else if (at_reload) begin
            cnt_nxt = `TPWM_CNT_RESTART;
        end else if (step) begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end
        if (!en) begin
            pwm_nxt = pol;
        end else if (at_reload) begin
            pwm_nxt = pol;
        end else if (at_match) begin
            pwm_nxt = ~pwm_r;
        end
        ev = '0;
        ev[`TPWM_ST_RELOAD] = at_reload;
        ev[`TPWM_ST_MATCH] = at_match && (icfg == `TPWM_ICFG_MATCH);
        stat_nxt = stat_r;
        if (hit(addr_i, `TPWM_ADDR_CLR)) stat_nxt = stat_nxt & ~wdata_i[1:0];
        stat_nxt = stat_nxt | ev;
        irq_nxt = |(stat_nxt & ien_nxt);
        rdata_nxt = '0;
        if (rd_i) begin
            case (addr_i)
                `TPWM_ADDR_CTL1: rdata_nxt = {24'h000000, ctl1_r};
                `TPWM_ADDR_CTL0: rdata_nxt = {16'h0000, ctl0_r};
                `TPWM_ADDR_COUNT: rdata_nxt = 32'(cnt_r);
                `TPWM_ADDR_MATCH: rdata_nxt = 32'(match_r);
                `TPWM_ADDR_RELOAD: rdata_nxt = 32'(reload_r);
                `TPWM_ADDR_STAT: rdata_nxt = {30'h00000000, stat_r};
                `TPWM_ADDR_IEN: rdata_nxt = {30'h00000000, ien_r};
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctl1_r <= '0;
            ctl0_r <= '0;
            cnt_r <= `TPWM_CNT_RESTART;
            match_r <= `TPWM_RST_MATCH;
            reload_r <= `TPWM_RST_RELOAD;
            stat_r <= '0;
            ien_r <= '0;
            pwm_r <= 1'b0;
            irq_r <= 1'b0;
            rdata_r <= '0;
        end else if (ce_i) begin
            ctl1_r <= ctl1_nxt;
            ctl0_r <= ctl0_nxt;
            cnt_r <= cnt_nxt;
            match_r <= match_nxt;
            reload_r <= reload_nxt;
            stat_r <= stat_nxt;
            ien_r <= ien_nxt;
            pwm_r <= pwm_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // deadband and pins

    tpwm_db_if dbif ();

    assign dbif.raw = pwm_r;
    assign dbif.dual = (mode == tpwm_pkg::TPWM_DUAL);
    assign dbif.dead = dead;

    tpwm_deadband u_db (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .db(dbif.gen)
    );

    assign timer_output_pin_o = dbif.p_out;
    assign timer_output_comp_o = dbif.n_out;
    assign irq_o = irq_r;
    assign rdata_o = rdata_r;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_wrap;
        ce_i && at_reload && !cnt_wr;
    endsequence

    sequence s_quiet;
        ce_i && !cnt_wr && !step;
    endsequence

    a_count_step: assert property (
        (ce_i && step && !at_reload && !cnt_wr) |=> cnt_r == $past(cnt_r) + CNT_W'(1))
        else $error("counter did not advance by one on a step");
    a_match_toggle: assert property (
        (ce_i && at_match) |=> pwm_r == !$past(pwm_r))
        else $error("output did not toggle at the match value");
    a_reload_irq: assert property (
        s_wrap |=> (cnt_r == `TPWM_CNT_RESTART && stat_r[`TPWM_ST_RELOAD]))
        else $error("reload did not restart count and flag status");
    a_pol_high: assert property (
        (ce_i && at_reload && !cnt_wr && pol && en && !hit(addr_i, `TPWM_ADDR_CTL1)) |=> pwm_r)
        else $error("output not high after reload with polarity one");
    a_pol_low: assert property (
        (ce_i && at_reload && !cnt_wr && !pol && en && !hit(addr_i, `TPWM_ADDR_CTL1)) |=> !pwm_r)
        else $error("output not low after reload with polarity zero");
    a_next_period: assert property (
        s_wrap ##1 s_quiet |=> cnt_r == `TPWM_CNT_RESTART)
        else $error("later period did not start from the restart value");
    a_start_count: assert property (
        (ce_i && cnt_wr) |=> cnt_r == $past(wdata_i[CNT_W-1:0]))
        else $error("written start count not taken");
    a_hold_off: assert property (
        (ce_i && !en && !cnt_wr && !hit(addr_i, `TPWM_ADDR_CTL1)) |=>
        ($stable(cnt_r) && pwm_r == pol))
        else $error("disabled timer moved or left the initial level");
    a_irq_level: assert property (
        irq_r |-> $past(|(stat_nxt & ien_nxt)) || !$past(ce_i))
        else $error("interrupt high without an enabled status bit");
endmodule : tpwm_core

`default_nettype wire

// [tpwm_load_model.sv]
/*
 * load model: a power stage on the pwm pin and its complement, measuring
 * the last high run and low run of the pin, and the both-low gap before its last rise.
 * assumes both pins are levels launched from the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tpwm_load_model (
    // clock
    input wire logic clock_i,
    // pins
    input wire logic pin_i,
    input wire logic comp_i,
    // measurements
    output logic [15:0] high_o,
    output logic [15:0] low_o,
    output logic [15:0] gap_o,
    output logic overlap_o
);
    logic pin_q = 1'b0;
    logic [15:0] run_r = 16'h0000;
    logic [15:0] low_run_r = 16'h0000;

    initial begin
        high_o = 16'h0000;
        low_o = 16'h0000;
        gap_o = 16'h0000;
        overlap_o = 1'b0;
    end

    always @(posedge clock_i) begin
        pin_q <= pin_i;
        if (pin_i !== pin_q) begin
            run_r <= 16'h0001;
            if (pin_q === 1'b1) high_o <= run_r;
            else low_o <= run_r;
        end else begin
            run_r <= run_r + 16'h0001;
        end
        // both switches on at once shorts the supply
        if (pin_i === 1'b1 && comp_i === 1'b1) overlap_o <= 1'b1;
        low_run_r <= (pin_i === 1'b0 && comp_i === 1'b0) ? low_run_r + 16'h0001 : 16'h0000;
        if (pin_i === 1'b1 && pin_q === 1'b0) gap_o <= low_run_r;
    end
endmodule : tpwm_load_model

`default_nettype wire

// [tpwm_core_bench.sv]
/*
 * self-checking bench of the pwm timer: register access, single and dual
 * output periods, start count, interrupt status, deadband.
 * assumes the pwm timer core and the load model in the same compile.
 */
`include "tpwm_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tpwm_core_bench;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h00000000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic pin_w;
    logic comp_w;
    logic irq_w;
    logic [15:0] high_w;
    logic [15:0] low_w;
    logic [15:0] gap_w;
    logic overlap_w;
    int errors = 0;
    int compares = 0;

    always #2 clock_i = ~clock_i;

    tpwm_core dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .timer_output_pin_o(pin_w), .timer_output_comp_o(comp_w), .irq_o(irq_w));

    tpwm_load_model load (.clock_i(clock_i), .pin_i(pin_w), .comp_i(comp_w),
        .high_o(high_w), .low_o(low_w), .gap_o(gap_w), .overlap_o(overlap_w));

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask : wr

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        check(what, rdata_o, exp);
        @(posedge clock_i);
    endtask : rdchk

    task automatic settle;
        @(posedge clock_i);
        #1;
    endtask : settle

    function automatic logic [31:0] c1(input logic en, input logic pol, input logic [2:0] pre);
        return {24'h000000, `TPWM_MODE_PWM, pre, pol, en};
    endfunction : c1

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(4 * 20000);
        errors++;
        close_out();
    end

    initial begin : main
        int n;
        int de;
        int dl [3] = '{0, 2, 200};
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        rdchk("count", `TPWM_ADDR_COUNT, 32'h00000001);
        rdchk("reload", `TPWM_ADDR_RELOAD, 32'h0000ffff);
        rdchk("match", `TPWM_ADDR_MATCH, 32'h00000000);
        rdchk("unmapped", 8'h20, 32'h00000000);
        rdchk("clear reg", `TPWM_ADDR_CLR, 32'h00000000);
        for (int p = 0; p < 2; p++) begin
            // setup order: disabled, config, values, enable last
            wr(`TPWM_ADDR_CTL1, c1(1'b0, p[0], 3'h1));
            wr(`TPWM_ADDR_CTL0, {30'h0, `TPWM_ICFG_MATCH});
            wr(`TPWM_ADDR_COUNT, 32'h00000001);
            wr(`TPWM_ADDR_MATCH, 32'h00000003);
            wr(`TPWM_ADDR_RELOAD, 32'h00000006);
            wr(`TPWM_ADDR_IEN, 32'h00000003);
            check("idle pin", pin_w, p[0]);
            wr(`TPWM_ADDR_CTL1, c1(1'b1, p[0], 3'h1));
            repeat (60) @(posedge clock_i);
            check("high run", high_w, p ? 4 : 8);
            check("low run", low_w, p ? 8 : 4);
            check("single comp", comp_w, 1'b0);
            rdchk("status", `TPWM_ADDR_STAT, 32'h00000003);
            check("irq", irq_w, 1'b1);
            wr(`TPWM_ADDR_CTL1, c1(1'b0, p[0], 3'h1));
            settle();
            check("stopped pin", pin_w, p[0]);
            wr(`TPWM_ADDR_IEN, 32'h00000000);
            settle();
            check("masked irq", irq_w, 1'b0);
            wr(`TPWM_ADDR_IEN, 32'h00000003);
            settle();
            check("unmasked irq", irq_w, 1'b1);
            wr(`TPWM_ADDR_CLR, 32'h00000003);
            rdchk("cleared", `TPWM_ADDR_STAT, 32'h00000000);
            check("cleared irq", irq_w, 1'b0);
        end
        // first period from a written start count
        wr(`TPWM_ADDR_MATCH, 32'h00000003);
        wr(`TPWM_ADDR_RELOAD, 32'h00000008);
        wr(`TPWM_ADDR_COUNT, 32'h00000007);
        wr(`TPWM_ADDR_IEN, 32'h00000001);
        wr(`TPWM_ADDR_CTL1, c1(1'b1, 1'b0, 3'h0));
        n = 0;
        while (irq_w !== 1'b1 && n < 20) begin
            settle();
            n++;
        end
        check("short first", n < 6, 1'b1);
        repeat (30) @(posedge clock_i);
        check("later period", high_w + low_w, 32'h00000008);
        // dual output with deadband, clamp above 128
        for (int i = 0; i < 3; i++) begin
            de = (dl[i] > 128) ? 128 : dl[i];
            wr(`TPWM_ADDR_CTL1, c1(1'b0, 1'b0, 3'h0));
            wr(`TPWM_ADDR_CLR, 32'h00000003);
            wr(`TPWM_ADDR_COUNT, 32'h00000001);
            wr(`TPWM_ADDR_MATCH, 32'h000000c8);
            wr(`TPWM_ADDR_CTL0, {16'h0, dl[i][7:0], 8'h08});
            wr(`TPWM_ADDR_RELOAD, 32'h00000190);
            wr(`TPWM_ADDR_CTL1, c1(1'b1, 1'b0, 3'h0));
            repeat (1000) @(posedge clock_i);
            check("dual high", high_w, 201 - de);
            check("dual low", low_w, 199 + de);
            check("dead gap", gap_w, de);
            check("overlap", overlap_w, 1'b0);
        end
        close_out();
    end
endmodule : tpwm_core_bench

`default_nettype wire
